// ### rtl/vil_map.svh
`ifndef VIL_MAP_SVH
`define VIL_MAP_SVH

// Register byte offsets
`define VIL_OFF_CTRL 8'h00
`define VIL_OFF_CFG 8'h04
`define VIL_OFF_IBOX 8'h08
`define VIL_OFF_MAP_LO 8'h0c
`define VIL_OFF_MAP_HI 8'h10
`define VIL_OFF_STATUS 8'h14
`define VIL_OFF_MASK 8'h18
`define VIL_OFF_STATE 8'h1c

// Control register fields
`define VIL_CTRL_START 0

// Settings register fields
`define VIL_CFG_SFCLR 0
`define VIL_CFG_TMREN 1
`define VIL_CFG_TOUT_LSB 2
`define VIL_CFG_TOUT_MSB 3
`define VIL_CFG_FAIR 4
`define VIL_CFG_VINIT 5
`define VIL_CFG_MBOX 6
`define VIL_CFG_SFA 7
`define VIL_CFG_SFN 8
`define VIL_CFG_ACA 9
`define VIL_CFG_IBEN 10
`define VIL_CFG_SLOT_LSB 16
`define VIL_CFG_SLOT_MSB 23

// Reset values of the settings
`define VIL_CFG_RST 32'h0001_007f
`define VIL_IBOX_RST 32'h0000_0000
`define VIL_MAP_LO_RST 32'hffff_ffff
`define VIL_MAP_HI_RST 24'hff_ffff

// Setting value ranges
`define VIL_TOUT_MIN 2'h1
`define VIL_TOUT_MAX 2'h3
`define VIL_SLOT_DEF 8'h01
`define VIL_LINE_MIN 8'h01
`define VIL_LINE_MAX 8'h07

// Event status bits
`define VIL_ST_DONE 0
`define VIL_ST_SFA 1
`define VIL_ST_SFN 2
`define VIL_ST_ACA 3
`define VIL_ST_W 4

`endif

// ### rtl/vil_pkg.sv
package vil_pkg;

   typedef enum logic [1:0] {
      VIL_IDLE = 2'b00,
      VIL_APPLY = 2'b01,
      VIL_DONE = 2'b10
   } vil_fsm_e;

   typedef struct packed {
      vil_fsm_e fsm;
      logic startReq;
      logic [31:0] cfg;
      logic [31:0] iboxCfg;
      logic [31:0] mapLo;
      logic [23:0] mapHi;
      logic [3:0] status;
      logic [3:0] mask;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
      logic sysfailRelease;
      logic timerEnable;
      logic [1:0] timeoutCode;
      logic [7:0] slotNumber;
      logic fairMode;
      logic [6:0] irqLevelEnable;
      logic [20:0] irqLevelRoute;
      logic [15:0] iboxBase;
      logic iboxEnable;
      logic msgBoxInit;
      logic vmeInitDone;
      logic loadDone;
      logic nmiAssertEn;
      logic nmiNegateEn;
      logic nmiAcfailEn;
      logic nmiPulse;
      logic irqOut;
   } vil_state_s;

   typedef struct packed {
      logic sysfailPrev;
      logic acfailPrev;
      logic sfAssertEv;
      logic sfNegateEv;
      logic acAssertEv;
   } vil_edge_s;

endpackage

// ### rtl/vil_nmi_if.sv
`timescale 1ns/1ps
interface vil_nmi_if;
   logic sfAssertEn;
   logic sfNegateEn;
   logic acAssertEn;
   logic sfAssertEv;
   logic sfNegateEv;
   logic acAssertEv;

   modport loader (
      output sfAssertEn,
      output sfNegateEn,
      output acAssertEn,
      input sfAssertEv,
      input sfNegateEv,
      input acAssertEv
   );

   modport detector (
      input sfAssertEn,
      input sfNegateEn,
      input acAssertEn,
      output sfAssertEv,
      output sfNegateEv,
      output acAssertEv
   );
endinterface

// ### rtl/vil_fail_edge.sv
`timescale 1ns/1ps
module vil_fail_edge
   import vil_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic sysfailN,
   input wire logic acfailN,
   vil_nmi_if.detector nmi
);

   vil_edge_s q;
   vil_edge_s d;

   // Edge detection; previous levels start negated so reset is no edge
   always_comb begin
      d = q;
      d.sysfailPrev = ~sysfailN;
      d.acfailPrev = ~acfailN;
      d.sfAssertEv = nmi.sfAssertEn & ~sysfailN & ~q.sysfailPrev;
      d.sfNegateEv = nmi.sfNegateEn & sysfailN & q.sysfailPrev;
      d.acAssertEv = nmi.acAssertEn & ~acfailN & ~q.acfailPrev;
      if (!resetn) begin
         d = '0;
      end
   end

   always_ff @(posedge clk_sys) begin
      q <= d;
   end

   assign nmi.sfAssertEv = q.sfAssertEv;
   assign nmi.sfNegateEv = q.sfNegateEv;
   assign nmi.acAssertEv = q.acAssertEv;

endmodule

// ### rtl/vil_config_loader.sv
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "vil_map.svh"
module vil_config_loader
   import vil_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic memReady,
   input wire logic sysfailN,
   input wire logic acfailN,
   output logic sysfailRelease,
   output logic timerEnable,
   output logic [1:0] timeoutCode,
   output logic [7:0] slotNumber,
   output logic fairMode,
   output logic [6:0] irqLevelEnable,
   output logic [20:0] irqLevelRoute,
   output logic [15:0] iboxBase,
   output logic iboxEnable,
   output logic msgBoxInit,
   output logic vmeInitDone,
   output logic loadDone,
   output logic nmiPulse,
   output logic irq
);

   // Clamp an out-of-range timeout code to the longest period
   function automatic logic [1:0] clampTimeout(input logic [1:0] code);
      if (code < `VIL_TOUT_MIN) begin
         return `VIL_TOUT_MAX;
      end
      return code;
   endfunction

   // A map byte enables its level only for lines 1 to 7
   function automatic logic mapValid(input logic [7:0] value);
      return (value >= `VIL_LINE_MIN) && (value <= `VIL_LINE_MAX);
   endfunction

   // Slot 0 is outside the legal range, fall back to the default
   function automatic logic [7:0] clampSlot(input logic [7:0] value);
      if (value == 8'h00) begin
         return `VIL_SLOT_DEF;
      end
      return value;
   endfunction

   vil_state_s q;
   vil_state_s d;
   vil_nmi_if nmi ();

   logic [55:0] mapAll;
   logic [6:0] mapEn;
   logic [20:0] mapLine;
   logic apbAccess;
   logic apbDone;
   logic [31:0] readData;
   logic addrHit;
   logic [3:0] evNow;

   assign mapAll = {q.mapHi, q.mapLo};

   // Per-level decode of the interrupt level map
   genvar gi;
   generate
      for (gi = 0; gi < 7; gi = gi + 1) begin : gLevel
         assign mapEn[gi] = mapValid(mapAll[gi*8 +: 8]);
         assign mapLine[gi*3 +: 3] = mapAll[gi*8 +: 3];
      end
   endgenerate

   // Fail-line edge detector sits in its own module
   vil_fail_edge uEdge (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .sysfailN(sysfailN),
      .acfailN(acfailN),
      .nmi(nmi.detector)
   );

   assign nmi.sfAssertEn = q.nmiAssertEn;
   assign nmi.sfNegateEn = q.nmiNegateEn;
   assign nmi.acAssertEn = q.nmiAcfailEn;

   // Events of this cycle, in status bit order
   always_comb begin
      evNow = '0;
      evNow[`VIL_ST_DONE] = (q.fsm == VIL_APPLY);
      evNow[`VIL_ST_SFA] = nmi.sfAssertEv;
      evNow[`VIL_ST_SFN] = nmi.sfNegateEv;
      evNow[`VIL_ST_ACA] = nmi.acAssertEv;
   end

   // Bus phase decode; answer comes one cycle into the access phase
   assign apbAccess = psel & penable;
   assign apbDone = apbAccess & q.pready;

   // Read mux and address hit
   always_comb begin
      readData = '0;
      addrHit = 1'b1;
      unique case (paddr)
         `VIL_OFF_CTRL: readData[`VIL_CTRL_START] = q.startReq;
         `VIL_OFF_CFG: readData = q.cfg;
         `VIL_OFF_IBOX: readData = q.iboxCfg;
         `VIL_OFF_MAP_LO: readData = q.mapLo;
         `VIL_OFF_MAP_HI: readData = {8'h00, q.mapHi};
         `VIL_OFF_STATUS: readData = {28'h0000000, q.status};
         `VIL_OFF_MASK: readData = {28'h0000000, q.mask};
         `VIL_OFF_STATE: readData = {29'h00000000, q.loadDone, q.fsm};
         default: begin
            readData = '0;
            addrHit = 1'b0;
         end
      endcase
   end

   // Next-state logic of the whole loader
   always_comb begin
      d = q;
      d.pready = apbAccess & ~q.pready;
      d.nmiPulse = |evNow[`VIL_ST_ACA:`VIL_ST_SFA];

      // Bus answer: data and error are taken one edge before the completing edge
      if (apbAccess && !q.pready) begin
         d.prdata = pwrite ? 32'h00000000 : readData;
         d.pslverr = ~addrHit;
      end

      // Register writes; settings are only frozen by the loader
      if (apbDone && pwrite) begin
         unique case (paddr)
            `VIL_OFF_CTRL: d.startReq = pwdata[`VIL_CTRL_START];
            `VIL_OFF_CFG: d.cfg = pwdata;
            `VIL_OFF_IBOX: d.iboxCfg = pwdata;
            `VIL_OFF_MAP_LO: d.mapLo = pwdata;
            `VIL_OFF_MAP_HI: d.mapHi = pwdata[23:0];
            `VIL_OFF_MASK: d.mask = pwdata[3:0];
            default: d.startReq = q.startReq;
         endcase
      end

      // Status clears on read, but an event in the same cycle wins
      if (apbDone && !pwrite && (paddr == `VIL_OFF_STATUS)) begin
         d.status = evNow;
      end else begin
         d.status = q.status | evNow;
      end

      // Loader sequence runs once per reset
      unique case (q.fsm)
         VIL_IDLE: begin
            if (q.startReq && memReady) begin
               d.fsm = VIL_APPLY;
            end
         end
         VIL_APPLY: begin
            // Settings applied regardless of the master flag
            d.sysfailRelease = q.cfg[`VIL_CFG_SFCLR];
            d.timerEnable = q.cfg[`VIL_CFG_TMREN];
            // Code is stored even when the timer stays off
            d.timeoutCode = clampTimeout(q.cfg[`VIL_CFG_TOUT_MSB:`VIL_CFG_TOUT_LSB]);
            if (q.cfg[`VIL_CFG_VINIT]) begin
               // Slot alone never selects controller role
               d.slotNumber = clampSlot(q.cfg[`VIL_CFG_SLOT_MSB:`VIL_CFG_SLOT_LSB]);
               d.fairMode = q.cfg[`VIL_CFG_FAIR];
               d.irqLevelEnable = mapEn;
               d.irqLevelRoute = mapLine;
               d.nmiAssertEn = q.cfg[`VIL_CFG_SFA];
               d.nmiNegateEn = q.cfg[`VIL_CFG_SFN];
               d.nmiAcfailEn = q.cfg[`VIL_CFG_ACA];
               d.iboxBase = q.iboxCfg[15:0];
               d.iboxEnable = q.cfg[`VIL_CFG_IBEN];
               d.msgBoxInit = q.cfg[`VIL_CFG_MBOX];
               d.vmeInitDone = 1'b1;
            end
            // Master flag off: the gated settings keep their idle values
            d.loadDone = 1'b1;
            d.fsm = VIL_DONE;
         end
         VIL_DONE: begin
            d.fsm = VIL_DONE;
         end
         default: begin
            d.fsm = VIL_IDLE;
         end
      endcase

      // Level interrupt follows the masked sticky status
      d.irqOut = |(d.status & q.mask);

      // Synchronous reset to the documented defaults
      if (!resetn) begin
         d = '0;
         d.fsm = VIL_IDLE;
         d.cfg = `VIL_CFG_RST;
         d.iboxCfg = `VIL_IBOX_RST;
         d.mapLo = `VIL_MAP_LO_RST;
         d.mapHi = `VIL_MAP_HI_RST;
         d.timerEnable = 1'b1;
         d.timeoutCode = `VIL_TOUT_MAX;
         d.slotNumber = `VIL_SLOT_DEF;
         d.fairMode = 1'b1;
      end
   end

   // One register holds every piece of state except the edge detector's
   always_ff @(posedge clk_sys) begin
      q <= d;
   end

   // Outputs straight from the state register
   assign pready = q.pready;
   assign prdata = q.prdata;
   assign pslverr = q.pslverr;
   assign sysfailRelease = q.sysfailRelease;
   assign timerEnable = q.timerEnable;
   assign timeoutCode = q.timeoutCode;
   assign slotNumber = q.slotNumber;
   assign fairMode = q.fairMode;
   assign irqLevelEnable = q.irqLevelEnable;
   assign irqLevelRoute = q.irqLevelRoute;
   assign iboxBase = q.iboxBase;
   assign iboxEnable = q.iboxEnable;
   assign msgBoxInit = q.msgBoxInit;
   assign vmeInitDone = q.vmeInitDone;
   assign loadDone = q.loadDone;
   assign nmiPulse = q.nmiPulse;
   assign irq = q.irqOut;

endmodule

// ### tb/vil_config_loader_monitor.sv
`timescale 1ns/1ps
module vil_config_loader_monitor (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic memReady,
   input wire logic sysfailN,
   input wire logic acfailN,
   input wire logic timerEnable,
   input wire logic [1:0] timeoutCode,
   input wire logic [7:0] slotNumber,
   input wire logic [6:0] irqLevelEnable,
   input wire logic [15:0] iboxBase,
   input wire logic iboxEnable,
   input wire logic msgBoxInit,
   input wire logic vmeInitDone,
   input wire logic loadDone,
   input wire logic nmiPulse
);
   // Single domain, so one clock and one reset for all checks
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("ready not in second access cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_err_unmapped: assert property (psel && penable && pready && paddr > 8'h1c
      |-> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
   a_tout_range: assert property (timeoutCode != 2'h0)
      else $error("timeout code out of range");
   a_slot_range: assert property (slotNumber != 8'h00)
      else $error("slot number zero");
   // Settings freeze once loaded, whatever software writes later
   a_cfg_hold: assert property (loadDone |=> $stable({timerEnable, timeoutCode,
      slotNumber, irqLevelEnable, iboxBase, iboxEnable})) else $error("settings moved");
   a_mem_first: assert property ($rose(loadDone) |-> $past(memReady, 2))
      else $error("load before memory ready");
   a_init_gate: assert property (loadDone && !vmeInitDone
      |-> irqLevelEnable == 7'h0 && !iboxEnable && !msgBoxInit) else $error("gated setting applied");
   a_mbox_gate: assert property (msgBoxInit |-> vmeInitDone && loadDone)
      else $error("mailbox init without interface init");
   a_nmi_cause: assert property (nmiPulse |-> vmeInitDone &&
      ($past(sysfailN, 2) != $past(sysfailN, 3) || !$past(acfailN, 2) && $past(acfailN, 3)))
      else $error("nmi without fail edge");
endmodule

bind vil_config_loader vil_config_loader_monitor vil_config_loader_monitor_i (
   .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable), .paddr(paddr),
   .pready(pready), .prdata(prdata), .pslverr(pslverr), .memReady(memReady),
   .sysfailN(sysfailN), .acfailN(acfailN), .timerEnable(timerEnable),
   .timeoutCode(timeoutCode), .slotNumber(slotNumber), .irqLevelEnable(irqLevelEnable),
   .iboxBase(iboxBase), .iboxEnable(iboxEnable), .msgBoxInit(msgBoxInit),
   .vmeInitDone(vmeInitDone), .loadDone(loadDone), .nmiPulse(nmiPulse));

// ### tb/vil_fail_model.sv
`timescale 1ns/1ps
module vil_fail_model (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic sysfailRelease,
   input wire logic sfHold,
   input wire logic acHold,
   output logic sysfailN,
   output logic acfailN
);
   // Bus fail lines; SYSFAIL stays asserted from power-up until released
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         sysfailN <= 1'b0;
         acfailN <= 1'b1;
      end else begin
         sysfailN <= sysfailRelease && !sfHold;
         acfailN <= !acHold;
      end
   end
endmodule

// ### tb/vil_config_loader_bench.sv
`timescale 1ns/1ps
`include "vil_map.svh"
module vil_config_loader_bench;
   logic clk_sys = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic memReady = 1'b0, sfHold = 1'b0, acHold = 1'b0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic pready, pslverr, sysfailRelease, timerEnable, fairMode, iboxEnable, msgBoxInit;
   logic vmeInitDone, loadDone, nmiPulse, irq, sysfailN, acfailN;
   logic [31:0] prdata;
   logic [1:0] timeoutCode;
   logic [7:0] slotNumber;
   logic [6:0] irqLevelEnable;
   logic [20:0] irqLevelRoute;
   logic [15:0] iboxBase;
   int num_errors = 0, n_checks = 0;
   logic [32:0] expQ[$];
   logic [31:0] cfgs [5] = '{32'h0005_07c1, 32'h0000_07fb, 32'h00ff_0226, `VIL_CFG_RST, 32'h0};

   always #25 clk_sys = ~clk_sys;

   vil_config_loader vil_config_loader_i (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .memReady(memReady), .sysfailN(sysfailN),
      .acfailN(acfailN), .sysfailRelease(sysfailRelease), .timerEnable(timerEnable),
      .timeoutCode(timeoutCode), .slotNumber(slotNumber), .fairMode(fairMode),
      .irqLevelEnable(irqLevelEnable), .irqLevelRoute(irqLevelRoute), .iboxBase(iboxBase),
      .iboxEnable(iboxEnable), .msgBoxInit(msgBoxInit), .vmeInitDone(vmeInitDone),
      .loadDone(loadDone), .nmiPulse(nmiPulse), .irq(irq));
   vil_fail_model vil_fail_model_i (.clk_sys(clk_sys), .resetn(resetn),
      .sysfailRelease(sysfailRelease), .sfHold(sfHold), .acHold(acHold),
      .sysfailN(sysfailN), .acfailN(acfailN));

   task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // One APB transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(negedge clk_sys); while (pready !== 1'b1);
      @(posedge clk_sys);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      expQ.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask

   // Read answers are compared against the oldest note, mid-cycle
   always @(negedge clk_sys) begin
      if (psel && penable && pready === 1'b1 && !pwrite)
         check({pslverr, prdata}, expQ.pop_front(), "read data");
   end

   function automatic logic [7:0] pick();
      int r;
      r = $urandom() % 10;
      return r < 8 ? 8'(r) : (r == 8 ? 8'hff : 8'h80);
   endfunction

   // Disabled levels carry no meaning in their route field
   function automatic logic [59:0] outv();
      logic [20:0] rm;
      for (int k = 0; k < 7; k++) rm[3*k+:3] = {3{irqLevelEnable[k]}};
      return {sysfailRelease, timerEnable, timeoutCode, slotNumber, fairMode, irqLevelEnable,
         irqLevelRoute & rm, iboxBase, iboxEnable, msgBoxInit, vmeInitDone};
   endfunction

   function automatic logic [59:0] expv(input logic [31:0] c, input logic [31:0] ib,
         input logic [55:0] mp);
      logic [6:0] en;
      logic [20:0] rt;
      logic v;
      v = c[5];
      en = 7'h0;
      rt = 21'h0;
      for (int k = 0; k < 7; k++) begin
         if (v && mp[8*k+:8] >= 8'h01 && mp[8*k+:8] <= 8'h07) begin
            en[k] = 1'b1;
            rt[3*k+:3] = mp[8*k+:3];
         end
      end
      return {c[0], c[1], c[3:2] == 2'h0 ? 2'h3 : c[3:2],
         (!v || c[23:16] == 8'h0) ? 8'h01 : c[23:16], c[4] | !v, en, rt,
         v ? ib[15:0] : 16'h0, v & c[10], v & c[6], v};
   endfunction

   // Reset, program, load, then stir the fail lines
   task automatic run(input logic [31:0] c, input logic [3:0] m);
      logic [31:0] lo;
      logic [31:0] ib;
      logic [23:0] hi;
      logic [3:0] st;
      int np;
      lo = {pick(), pick(), pick(), pick()};
      hi = {pick(), pick(), pick()};
      ib = $urandom();
      np = 0;
      st = {c[9] & c[5], c[8] & c[5] & c[0], c[7] & c[5] & c[0], 1'b1};
      @(posedge clk_sys);
      resetn <= 1'b0;
      memReady <= 1'b0;
      sfHold <= 1'b0;
      acHold <= 1'b0;
      repeat (10) @(posedge clk_sys);
      resetn <= 1'b1;
      check(outv(), expv(32'h2, 32'h0, 56'h0), "reset outputs");
      rd(`VIL_OFF_CFG, {1'b0, `VIL_CFG_RST});
      rd(`VIL_OFF_MAP_HI, {9'h0, `VIL_MAP_HI_RST});
      rd(8'h24, 33'h1_0000_0000);
      apb(1'b1, `VIL_OFF_CFG, c);
      apb(1'b1, `VIL_OFF_IBOX, ib);
      apb(1'b1, `VIL_OFF_MAP_LO, lo);
      apb(1'b1, `VIL_OFF_MAP_HI, {8'h0, hi});
      apb(1'b1, `VIL_OFF_MASK, {28'h0, m});
      apb(1'b1, `VIL_OFF_CTRL, 32'h1);
      repeat (5) @(negedge clk_sys);
      check(loadDone, 1'b0, "load before memory");
      for (int i = 0; i < 40; i++) begin
         @(posedge clk_sys);
         memReady <= 1'b1;
         sfHold <= i >= 10 && i < 16;
         acHold <= i >= 22;
         @(negedge clk_sys);
         np += (nmiPulse === 1'b1);
      end
      check({loadDone, irq}, {1'b1, |(st & m)}, "done and irq");
      apb(1'b1, `VIL_OFF_CFG, ~c);
      apb(1'b1, `VIL_OFF_CTRL, 32'h1);
      check(outv(), expv(c, ib, {hi, lo}), "loaded outputs");
      check(np, 2 * st[2] + st[1] + st[3], "nmi count");
      rd(`VIL_OFF_STATUS, {29'h0, st});
      @(negedge clk_sys);
      check(irq, 1'b0, "irq after clear");
      rd(`VIL_OFF_STATUS, 33'h0);
   endtask

   // Main sequence: four fixed setting sets and one random
   initial begin
      void'($urandom(32'ha064));
      for (int r = 0; r < 5; r++) begin
         run(r == 4 ? $urandom() : cfgs[r], r == 0 ? 4'hf : 4'($urandom()));
         $display("test %0d done", r);
      end
      stop_test();
   end

   // Hang guard, well beyond five loads
   initial begin
      repeat (20000) @(posedge clk_sys);
      num_errors++;
      stop_test();
   end
endmodule
